// ---- rtl/fault_led_diag_filter_config.sv ----
// led source selection, fault latching, diagnostic filtering and led stretch
// Function
// - under internal led control, current-limit lights a fault led only if bit 7 set
// - bit 6 latches overload, open-wire and short fault bits; clear gives live bits
// - global error faults always latch
// - demag and supply-ok faults always latch
// - internal fault led stays on until fault gone and minimum on-time expired
// - blanking 4ms when bit 5 is 0, 8ms when 1
// - bit 5 also selects fault led on-time under internal control
// - bit 4 at 0 gives real-time diagnostics through a 68us filter only
// - bit 4 at 1 (reset) blanks and filters short and open-wire bits
// - internal fault led control forces blanking and filtering on
// - bits 3:2 pick minimum led on-time: none, 1s, 2s, 3s
// - bit 1 picks status leds from line states or override bits
// - bit 0 picks fault leds from diagnostics or override bits
// - internal fault led is the or of all enabled channel diagnostics
`timescale 1ns/1ps
module fault_led_diag_filter_config #(
   parameter int NCH       = 4,
   parameter int MS_CYCLES = led_diag_pkg::MS_CYC,
   parameter int S_CYCLES  = led_diag_pkg::CLK_HZ
) (
   input  wire logic           aclk,
   input  wire logic           aresetn,
   input  wire logic [7:0]     s_axi_awaddr,
   input  wire logic           s_axi_awvalid,
   output logic                s_axi_awready,
   input  wire logic [31:0]    s_axi_wdata,
   input  wire logic [3:0]     s_axi_wstrb,
   input  wire logic           s_axi_wvalid,
   output logic                s_axi_wready,
   output logic [1:0]          s_axi_bresp,
   output logic                s_axi_bvalid,
   input  wire logic           s_axi_bready,
   input  wire logic [7:0]     s_axi_araddr,
   input  wire logic           s_axi_arvalid,
   output logic                s_axi_arready,
   output logic [31:0]         s_axi_rdata,
   output logic [1:0]          s_axi_rresp,
   output logic                s_axi_rvalid,
   input  wire logic           s_axi_rready,
   input  wire logic [NCH-1:0] channel_line,
   input  wire logic [NCH-1:0] demag_fault,
   input  wire logic [NCH-1:0] short_to_supply_fault,
   input  wire logic [NCH-1:0] supply_overvoltage_fault,
   input  wire logic [NCH-1:0] open_wire_off_fault,
   input  wire logic [NCH-1:0] above_supply_fault,
   input  wire logic [NCH-1:0] current_limit_fault,
   input  wire logic [NCH-1:0] overload_fault,
   input  wire logic [NCH-1:0] channel_supply_ok_fault,
   input  wire logic [7:0]     global_fault,
   output logic [NCH-1:0]      status_led,
   output logic [NCH-1:0]      fault_led,
   output logic                irq
);
   localparam int CW  = 32;
   localparam int NIN = 9 * NCH + 8;

   typedef struct packed {
      logic [NIN-1:0]  s1;
      logic [NIN-1:0]  s2;
      logic [7:0]      cfg;
      logic [7:0]      override;
      logic [NCH-1:0]  ovl_lat;
      logic [NCH-1:0]  ow_lat;
      logic [NCH-1:0]  sh_lat;
      logic [NCH-1:0]  demag_lat;
      logic [NCH-1:0]  vok_lat;
      logic [7:0]      glob_lat;
      logic [NCH-1:0]  fault_led_bit_on;
      logic [NCH*CW-1:0] hold;
      logic [2:0]      irq_stat;
      logic [2:0]      irq_mask;
      logic            aw_got;
      logic            w_got;
      logic [7:0]      awaddr;
      logic [31:0]     wdata;
      logic [3:0]      wstrb;
      logic            bvalid;
      logic [1:0]      bresp;
      logic            rvalid;
      logic [31:0]     rdata;
      logic [1:0]      rresp;
      logic [NCH-1:0]  status_led_bit_o;
      logic [NCH-1:0]  fault_led_bit_o;
      logic            irq_o;
   } state_t;
   state_t st_reg, st_next;

   // synchronised diagnostic views
   logic [NCH-1:0] line_s, demag_s, short_s, ov_s, ow_s, above_s, cl_s, ovl_s, vok_s;
   logic [7:0]     glob_s;
   assign {line_s, demag_s, short_s, ov_s, ow_s, above_s, cl_s, ovl_s, vok_s, glob_s} =
      st_reg.s2;

   logic           internal_led;
   logic           blank_mode;
   logic [CW-1:0]  blank_cyc;
   logic [NCH-1:0] ow_f, short_f;
   assign internal_led = !st_reg.cfg[led_diag_pkg::FAULT_LED_BIT_SW_BIT];
   assign blank_mode   = st_reg.cfg[led_diag_pkg::FILT_EN_BIT] || internal_led;
   // blanking length from the long select bit
   assign blank_cyc = st_reg.cfg[led_diag_pkg::LONG_BLK_BIT] ?
      CW'(led_diag_pkg::BLANK_LONG_MS * MS_CYCLES) :
      CW'(led_diag_pkg::BLANK_SHORT_MS * MS_CYCLES);

   // open-wire and short filters per channel; both use the 68us real-time limit when not blanking
   genvar g;
   generate
      for (g = 0; g < NCH; g++) begin : g_ch
         diag_filter #(.RT_CYC(led_diag_pkg::RT_FILTER_CYC), .CW(CW)) u_ow (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .raw        (ow_s[g]),
            .blank_mode (blank_mode),
            .blank_cyc  (blank_cyc),
            .filtered   (ow_f[g])
         );
         diag_filter #(.RT_CYC(led_diag_pkg::RT_FILTER_CYC), .CW(CW)) u_sh (
            .aclk       (aclk),
            .aresetn    (aresetn),
            .raw        (short_s[g]),
            .blank_mode (blank_mode),
            .blank_cyc  (blank_cyc),
            .filtered   (short_f[g])
         );
      end
   endgenerate

   // minimum on-time in cycles; long select doubles it under internal control
   function automatic logic [CW-1:0] min_on(input logic [1:0] sel, input logic lng);
      logic [CW-1:0] c;
      c = CW'(sel) * CW'(led_diag_pkg::MIN_ON_UNIT_S * S_CYCLES);
      return lng ? (c << 1) : c;
   endfunction

   // byte-lane merge for writes to an 8-bit register
   function automatic logic [7:0] merge8(input logic [7:0] old, input logic [31:0] d,
                                         input logic [3:0] be);
      return be[0] ? d[7:0] : old;
   endfunction

   always_comb begin
      logic [NCH-1:0] ind;
      logic [NCH-1:0] rd_ovl, rd_ow, rd_sh, rd_vok;
      logic           rd_glob, rd_stat, wr_go, ar_go;
      logic [2:0]     ev;
      logic [CW-1:0]  cnt;
      logic [31:0]    rv;
      logic           hit;
      ind = '0; rd_ovl = '0; rd_ow = '0; rd_sh = '0; rd_vok = '0;
      rd_glob = 1'b0; rd_stat = 1'b0; ev = '0; cnt = '0; rv = '0; hit = 1'b1;
      wr_go = 1'b0;
      ar_go = 1'b0;
      st_next = st_reg;
      // two-stage synchroniser for the pins and detector levels
      st_next.s1 = {channel_line, demag_fault, short_to_supply_fault,
                    supply_overvoltage_fault, open_wire_off_fault, above_supply_fault,
                    current_limit_fault, overload_fault, channel_supply_ok_fault,
                    global_fault};
      st_next.s2 = st_reg.s1;

      // axi write: address and data taken in either order
      if (s_axi_awvalid && !st_reg.aw_got && !st_reg.bvalid) begin
         st_next.aw_got = 1'b1;
         st_next.awaddr = s_axi_awaddr;
      end
      if (s_axi_wvalid && !st_reg.w_got && !st_reg.bvalid) begin
         st_next.w_got = 1'b1;
         st_next.wdata = s_axi_wdata;
         st_next.wstrb = s_axi_wstrb;
      end
      wr_go = st_reg.aw_got && st_reg.w_got;
      if (wr_go) begin
         st_next.aw_got = 1'b0;
         st_next.w_got  = 1'b0;
         st_next.bvalid = 1'b1;
         st_next.bresp  = led_diag_pkg::RESP_OKAY;
         unique case (st_reg.awaddr)
            led_diag_pkg::CFG_ADDR:
               st_next.cfg = merge8(st_reg.cfg, st_reg.wdata, st_reg.wstrb);
            led_diag_pkg::OVERRIDE_ADDR:
               st_next.override = merge8(st_reg.override, st_reg.wdata, st_reg.wstrb);
            led_diag_pkg::IRQ_MASK_ADDR:
               st_next.irq_mask = st_reg.wstrb[0] ? st_reg.wdata[2:0] : st_reg.irq_mask;
            default: st_next.bresp = led_diag_pkg::RESP_SLVERR;
         endcase
      end
      if (st_reg.bvalid && s_axi_bready) begin
         st_next.bvalid = 1'b0;
      end

      // axi read: data returned one cycle after the address is taken
      ar_go = s_axi_arvalid && !st_reg.rvalid;
      if (ar_go) begin
         unique case (s_axi_araddr)
            led_diag_pkg::CFG_ADDR:       rv = {24'h0, st_reg.cfg};
            led_diag_pkg::OVERRIDE_ADDR:  rv = {24'h0, st_reg.override};
            led_diag_pkg::OVERLOAD_ADDR: begin
               rv = 32'(st_reg.ovl_lat);
               rd_ovl = '1;
            end
            led_diag_pkg::OPEN_WIRE_ADDR: begin
               rv = 32'({st_reg.sh_lat, st_reg.ow_lat});
               rd_ow = '1;
            end
            led_diag_pkg::SHORT_ADDR: begin
               rv = 32'({st_reg.vok_lat, st_reg.demag_lat});
               rd_sh = '1;
               rd_vok = '1;
            end
            led_diag_pkg::GLOBAL_ADDR: begin
               rv = {24'h0, st_reg.glob_lat};
               rd_glob = 1'b1;
            end
            led_diag_pkg::IRQ_STAT_ADDR: begin
               rv = 32'(st_reg.irq_stat);
               rd_stat = 1'b1;
            end
            led_diag_pkg::IRQ_MASK_ADDR: rv = 32'(st_reg.irq_mask);
            led_diag_pkg::LED_STAT_ADDR: rv = 32'({st_reg.fault_led_bit_o, st_reg.status_led_bit_o});
            default: hit = 1'b0;
         endcase
         st_next.rvalid = 1'b1;
         st_next.rdata  = rv;
         st_next.rresp  = hit ? led_diag_pkg::RESP_OKAY : led_diag_pkg::RESP_SLVERR;
      end
      if (st_reg.rvalid && s_axi_rready) begin
         st_next.rvalid = 1'b0;
      end

      // latched fault bits; overload, open-wire and short go live when latching is off; read clears only
      // bits whose condition is gone, and a present condition keeps them set
      if (st_reg.cfg[led_diag_pkg::LATCH_EN_BIT]) begin
         st_next.ovl_lat = ovl_s | (st_reg.ovl_lat & ~rd_ovl);
         st_next.ow_lat  = ow_f | (st_reg.ow_lat & ~rd_ow);
         st_next.sh_lat  = short_f | (st_reg.sh_lat & ~rd_ow);
      end else begin
         st_next.ovl_lat = ovl_s;
         st_next.ow_lat  = ow_f;
         st_next.sh_lat  = short_f;
      end
      st_next.demag_lat = demag_s | (st_reg.demag_lat & ~rd_sh);
      st_next.vok_lat   = vok_s | (st_reg.vok_lat & ~rd_vok);
      st_next.glob_lat  = glob_s | (st_reg.glob_lat & ~{8{rd_glob}});

      // internal fault indication per channel, then stretch
      for (int i = 0; i < NCH; i++) begin
         ind[i] = demag_s[i] | short_f[i] | ov_s[i] | ow_f[i] | above_s[i] |
                  (cl_s[i] & st_reg.cfg[led_diag_pkg::CL_EN_BIT]) |
                  ovl_s[i] | vok_s[i];
         cnt = st_reg.hold[i*CW +: CW];
         if (ind[i]) begin
            st_next.fault_led_bit_on[i]      = 1'b1;
            st_next.hold[i*CW +: CW] = min_on(st_reg.cfg[led_diag_pkg::MIN_ON_LSB +: 2],
                                              st_reg.cfg[led_diag_pkg::LONG_BLK_BIT]);
         end else if (cnt != '0) begin
            st_next.hold[i*CW +: CW] = cnt - 1'b1;
         end else begin
            st_next.fault_led_bit_on[i] = 1'b0;
         end
      end

      // leds: software override or internal sources
      st_next.status_led_bit_o = st_reg.cfg[led_diag_pkg::STATUS_LED_BIT_SW_BIT] ?
         st_reg.override[NCH-1:0] : line_s;
      st_next.fault_led_bit_o = internal_led ? st_reg.fault_led_bit_on :
         st_reg.override[2*NCH-1:NCH];

      // events: new latched overload, open/short, global; set beats read clear
      ev[0] = |(st_next.ovl_lat & ~st_reg.ovl_lat);
      ev[1] = |((st_next.ow_lat & ~st_reg.ow_lat) | (st_next.sh_lat & ~st_reg.sh_lat));
      ev[2] = |(st_next.glob_lat & ~st_reg.glob_lat);
      st_next.irq_stat = ev | (st_reg.irq_stat & ~{3{rd_stat}});
      st_next.irq_o    = |(st_next.irq_stat & st_reg.irq_mask);
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg     <= '0;
         st_reg.cfg <= led_diag_pkg::CFG_RESET;
      end else begin
         st_reg <= st_next;
      end
   end

   assign s_axi_awready = !st_reg.aw_got && !st_reg.bvalid;
   assign s_axi_wready  = !st_reg.w_got && !st_reg.bvalid;
   assign s_axi_bvalid  = st_reg.bvalid;
   assign s_axi_bresp   = st_reg.bresp;
   assign s_axi_arready = !st_reg.rvalid;
   assign s_axi_rvalid  = st_reg.rvalid;
   assign s_axi_rdata   = st_reg.rdata;
   assign s_axi_rresp   = st_reg.rresp;
   assign status_led    = st_reg.status_led_bit_o;
   assign fault_led     = st_reg.fault_led_bit_o;
   assign irq           = st_reg.irq_o;
endmodule

// ---- rtl/led_diag_pkg.sv ----
// constants and register layout for the fault led and diagnostic filter block
package led_diag_pkg;
   // register byte addresses; the config index 0x0a is not word aligned, so it is scaled by four
   localparam logic [7:0] CFG_INDEX      = 8'h0a;
   localparam logic [7:0] CFG_ADDR       = 8'h28;   // 4 * CFG_INDEX
   localparam logic [7:0] OVERRIDE_ADDR  = 8'h00;
   localparam logic [7:0] OVERLOAD_ADDR  = 8'h04;
   localparam logic [7:0] OPEN_WIRE_ADDR = 8'h08;
   localparam logic [7:0] SHORT_ADDR     = 8'h0c;
   localparam logic [7:0] GLOBAL_ADDR    = 8'h10;
   localparam logic [7:0] IRQ_STAT_ADDR  = 8'h14;
   localparam logic [7:0] IRQ_MASK_ADDR  = 8'h18;
   localparam logic [7:0] LED_STAT_ADDR  = 8'h1c;
   // config field positions
   localparam int CL_EN_BIT     = 7;
   localparam int LATCH_EN_BIT  = 6;
   localparam int LONG_BLK_BIT  = 5;
   localparam int FILT_EN_BIT   = 4;
   localparam int MIN_ON_LSB    = 2;
   localparam int STATUS_LED_BIT_SW_BIT   = 1;
   localparam int FAULT_LED_BIT_SW_BIT   = 0;
   localparam logic [7:0] CFG_RESET = 8'h53;
   // timing
   localparam int CLK_HZ        = 10_000_000;
   localparam int BLANK_SHORT_MS = 4;
   localparam int BLANK_LONG_MS  = 8;
   localparam int RT_FILTER_NS   = 68_000;
   localparam int RT_FILTER_CYC  = (RT_FILTER_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int MS_CYC         = CLK_HZ / 1000;
   localparam int MIN_ON_UNIT_S  = 1;
   // axi responses
   localparam logic [1:0] RESP_OKAY   = 2'b00;
   localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- rtl/diag_filter.sv ----
// one channel's blanking and real-time filter for an off-state diagnostic
`timescale 1ns/1ps
module diag_filter #(
   parameter int RT_CYC = 680,
   parameter int CW     = 20
) (
   input  wire logic          aclk,
   input  wire logic          aresetn,
   input  wire logic          raw,
   input  wire logic          blank_mode,
   input  wire logic [CW-1:0] blank_cyc,
   output logic               filtered
);
   typedef struct packed {
      logic [CW-1:0] count;
      logic          out;
   } filt_t;
   filt_t st_reg, st_next;

   // output follows raw once raw has been steady for the selected time;
   // a glitch restarts the count so short spikes never reach the fault bit
   always_comb begin
      logic [CW-1:0] lim;
      lim = blank_mode ? blank_cyc : CW'(RT_CYC);
      st_next = st_reg;
      if (raw == st_reg.out) begin
         st_next.count = '0;
      end else if (st_reg.count + 1'b1 >= lim) begin
         st_next.out   = raw;
         st_next.count = '0;
      end else begin
         st_next.count = st_reg.count + 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_reg <= '0;
      end else begin
         st_reg <= st_next;
      end
   end
   assign filtered = st_reg.out;
endmodule

// ---- testbench/fault_led_diag_filter_config_checker.sv ----
// register bus handshake assertions for the fault led block
`timescale 1ns/1ps
module fault_led_diag_filter_config_checker (
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready
);
   default clocking dc @(posedge aclk);
   endclocking
   default disable iff (!aresetn);
   // write steps: both channels taken, then a two-edge wait for the answer
   sequence both_taken;
      s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   endsequence
   sequence resp_after_two;
      !s_axi_bvalid ##1 s_axi_bvalid;
   endsequence
   write_answer_a: assert property (both_taken |=> resp_after_two)
      else $error("write response not two edges after the write");
   read_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read data not one edge after the address");
   // a second request must wait until the answer is gone
   write_refuse_a: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write accepted while response pending");
   read_refuse_a: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read accepted while data pending");
   bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped before taken");
   rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid && $stable(s_axi_rdata) && $stable(s_axi_rresp))
      else $error("read data dropped before taken");
   bresp_release_a: assert property (s_axi_bvalid && s_axi_bready |=>
      !s_axi_bvalid && s_axi_awready && s_axi_wready)
      else $error("write channel not free after response");
   rdata_release_a: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
      else $error("read channel not free after data");
   upper_zero_a: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("upper read bits not zero");
endmodule

bind fault_led_diag_filter_config fault_led_diag_filter_config_checker chk_i (.aclk, .aresetn,
   .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
   .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
   .s_axi_rready);

// ---- testbench/fault_led_diag_filter_config_tb.sv ----
// self-checking bench for the fault led and diagnostic filter block
`timescale 1ns/1ps
module fault_led_diag_filter_config_tb;
   localparam logic [7:0] CFG = led_diag_pkg::CFG_ADDR;
   localparam logic [1:0] OK  = led_diag_pkg::RESP_OKAY;
   logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
   logic        awready, wready, bvalid, arready, rvalid, irq;
   logic [7:0]  awaddr, araddr, glob;
   logic [31:0] wdata, rdata;
   logic [1:0]  bresp, rresp;
   logic [3:0]  line, demag, shrt, ovv, opw, abv, clim, ovl, sok, status_led, fault_led;
   int          n_mismatch = 0;
   int          n_checks = 0;

   fault_led_diag_filter_config #(.NCH(4), .MS_CYCLES(10), .S_CYCLES(100)) dut (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .channel_line(line), .demag_fault(demag), .short_to_supply_fault(shrt),
      .supply_overvoltage_fault(ovv), .open_wire_off_fault(opw), .above_supply_fault(abv),
      .current_limit_fault(clim), .overload_fault(ovl), .channel_supply_ok_fault(sok),
      .global_fault(glob), .status_led(status_led), .fault_led(fault_led), .irq(irq));

   // 10 MHz clock
   initial begin
      aclk = 1'b0;
      forever #50 aclk = ~aclk;
   end

   task automatic stop_test;
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
         $display("NO MISMATCHES");
      end else begin
         $display("MISMATCHES SEEN");
      end
      $finish;
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   task automatic cyc(input int n);
      repeat (n) @(posedge aclk);
   endtask

   // bus tasks are entered just after an edge and leave one edge after the answer
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      @(posedge aclk);
      while (awvalid || wvalid || !bvalid) begin
         if (awready) awvalid <= 1'b0;
         if (wready) wvalid <= 1'b0;
         @(posedge aclk);
      end
      chk(32'(bresp), 32'(er), "write response");
      bready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge aclk);
      while (!arready) @(posedge aclk);
      arvalid <= 1'b0;
      @(posedge aclk);
      while (!rvalid) @(posedge aclk);
      chk(rdata, exp, "read data");
      chk(32'(rresp), 32'(er), "read response");
      rready <= 1'b0;
      @(posedge aclk);
   endtask

   task automatic t_bus;
      rd(CFG, 32'h53, OK);
      chk(32'({irq, status_led, fault_led}), 32'h0, "reset outputs");
      wr(CFG, 32'haa, OK);
      rd(CFG, 32'haa, OK);
      rd(8'h20, 32'h0, led_diag_pkg::RESP_SLVERR);
      wr(8'h24, 32'hff, led_diag_pkg::RESP_SLVERR);
      wr(CFG, 32'h53, OK);
      wr(led_diag_pkg::OVERRIDE_ADDR, 32'ha5, OK);
      cyc(4);
      chk(32'({status_led, fault_led}), 32'h5a, "override leds");
      wr(CFG, 32'h51, OK);
      line <= 4'h9;
      cyc(8);
      chk(32'({status_led, fault_led}), 32'h9a, "line status leds");
      line <= 4'h0;
      wr(CFG, 32'h53, OK);
      $display("test bus and override done");
   endtask

   // overload events, interrupt mask, latching and read clear
   task automatic t_latch;
      ovl <= 4'h4;
      cyc(5);
      ovl <= 4'h0;
      cyc(6);
      chk(32'(irq), 32'h0, "masked irq");
      wr(led_diag_pkg::IRQ_MASK_ADDR, 32'h1, OK);
      cyc(3);
      chk(32'(irq), 32'h1, "unmasked irq");
      rd(led_diag_pkg::OVERLOAD_ADDR, 32'h4, OK);
      rd(led_diag_pkg::OVERLOAD_ADDR, 32'h0, OK);
      rd(led_diag_pkg::IRQ_STAT_ADDR, 32'h1, OK);
      cyc(3);
      chk(32'(irq), 32'h0, "irq after clear");
      ovl <= 4'h4;
      cyc(6);
      rd(led_diag_pkg::OVERLOAD_ADDR, 32'h4, OK);
      rd(led_diag_pkg::OVERLOAD_ADDR, 32'h4, OK);
      ovl <= 4'h0;
      wr(CFG, 32'h13, OK);
      ovl <= 4'h2;
      demag <= 4'h1;
      sok <= 4'h2;
      glob <= 8'h08;
      cyc(5);
      {ovl, demag, sok, glob} <= 20'h0;
      cyc(6);
      rd(led_diag_pkg::OVERLOAD_ADDR, 32'h0, OK);
      rd(led_diag_pkg::SHORT_ADDR, 32'h21, OK);
      rd(led_diag_pkg::GLOBAL_ADDR, 32'h08, OK);
      rd(led_diag_pkg::IRQ_STAT_ADDR, 32'h5, OK);
      $display("test latching done");
   endtask

   task automatic t_internal;
      wr(CFG, 32'h50, OK);
      clim <= 4'h1;
      cyc(8);
      chk(32'(fault_led), 32'h0, "current limit hidden");
      wr(CFG, 32'hd0, OK);
      cyc(4);
      chk(32'(fault_led), 32'h1, "current limit shown");
      clim <= 4'h0;
      abv <= 4'h2;
      cyc(8);
      chk(32'(fault_led), 32'h2, "above supply");
      abv <= 4'h0;
      ovl <= 4'h8;
      cyc(8);
      chk(32'(fault_led), 32'h8, "overload");
      {ovl, ovv, demag, sok, shrt} <= 20'h04128;
      cyc(60);
      chk(32'(fault_led), 32'hf, "other diagnostics");
      {ovv, demag, sok, shrt} <= 16'h0;
      cyc(60);
      chk(32'(fault_led), 32'h0, "led off despite latch");
      rd(led_diag_pkg::OPEN_WIRE_ADDR, 32'h80, OK);
      $display("test internal leds done");
   endtask

   task automatic stretch(input logic [31:0] cfg, input int on_at, input int off_at);
      wr(CFG, cfg, OK);
      clim <= 4'h1;
      cyc(5);
      clim <= 4'h0;
      cyc(on_at);
      chk(32'(fault_led), 32'h1, "stretched on");
      cyc(off_at - on_at);
      chk(32'(fault_led), 32'h0, "stretched off");
   endtask

   task automatic blank(input logic [31:0] cfg, input int off_at, input int on_at);
      wr(CFG, cfg, OK);
      opw <= 4'h2;
      cyc(off_at);
      chk(32'(fault_led), 32'h0, "blanked");
      cyc(on_at - off_at);
      chk(32'(fault_led), 32'h2, "after blanking");
      opw <= 4'h0;
      cyc(200);
   endtask

   task automatic t_filter;
      wr(CFG, 32'h53, OK);
      opw <= 4'h4;
      cyc(20);
      rd(led_diag_pkg::OPEN_WIRE_ADDR, 32'h0, OK);
      cyc(40);
      rd(led_diag_pkg::OPEN_WIRE_ADDR, 32'h4, OK);
      opw <= 4'h0;
      cyc(200);
      rd(led_diag_pkg::OPEN_WIRE_ADDR, 32'h4, OK);
      wr(CFG, 32'h43, OK);
      opw <= 4'h2;
      cyc(300);
      rd(led_diag_pkg::OPEN_WIRE_ADDR, 32'h0, OK);
      cyc(420);
      rd(led_diag_pkg::OPEN_WIRE_ADDR, 32'h2, OK);
      opw <= 4'h0;
      $display("test filter done");
   endtask

   // watchdog well beyond the roughly 2800 cycles the tests need
   initial begin
      #(30000 * 100);
      n_mismatch++;
      stop_test();
   end

   initial begin
      aresetn = 1'b0;
      {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
      {awaddr, araddr, glob, wdata} = 56'h0;
      {line, demag, shrt, ovv, opw, abv, clim, ovl, sok} = 36'h0;
      repeat (20) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      t_bus();
      t_latch();
      t_internal();
      stretch(32'hd4, 50, 120);
      stretch(32'hd8, 150, 220);
      stretch(32'hdc, 250, 320);
      stretch(32'hf4, 150, 220);
      blank(32'h80, 30, 60);
      blank(32'ha0, 70, 100);
      $display("test stretch and blanking done");
      t_filter();
      stop_test();
   end
endmodule
